// ### hdl/ssm_monitor.sv
// safety status monitor: function/system flags and time-to-safe-speed timers
//
// Operation
// - function a flags in bits 0..2 of function word, bit 3 reserved zero.
// - function b flags in bits 4..6 of function word, bit 7 reserved zero.
// - flag encoding: standby 000, monitoring mon, safe mon+safe, baseblock safe+hbb.
// - other side in baseblock forces active function to safe+hbb, standby stays zero.
// - system bit 0 set when either function is monitoring.
// - system bit 1 set only when both functions report the safe flag.
// - system bit 2 set when either function reports baseblock.
// - two millisecond timers, one per function, zero after reset.
// - plain baseblock selection measures nothing, timer reads zero.
// - decel baseblock and position modes use speed detection error as safe speed.
// - limited speed mode uses configured monitoring speed as safe speed.
// - timer starts at request on and stops when speed reaches safe speed.
// - stored time updates every time speed arrives at safe speed.
// - watching for arrival continues until request input turns off.
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns

module ssm_monitor #(
    parameter int TICK_CYCLES = ssm_pkg::TICK_CYCLES,
    parameter int TIME_W      = ssm_pkg::DATA_W
) (
    input  wire logic                        clk_sys_in,
    input  wire logic                        nrst_in,
    input  wire logic [1:0]                  state_a_in,
    input  wire logic [1:0]                  state_b_in,
    input  wire logic                        req_a_in,
    input  wire logic                        req_b_in,
    input  wire logic [ssm_pkg::SPEED_W-1:0] speed_in,
    input  wire logic [3:0]                  addr_in,
    input  wire logic [ssm_pkg::DATA_W-1:0]  wdata_in,
    input  wire logic                        wr_in,
    input  wire logic                        rd_in,
    output logic      [ssm_pkg::DATA_W-1:0]  rdata_out,
    output logic      [7:0]                  func_flags_out,
    output logic      [7:0]                  sys_flags_out,
    output logic                             irq_out
);

    // the tick counter is 16 bits wide, so TICK_CYCLES must stay at or below 65536
    localparam logic [15:0] TICK_MAX = 16'(TICK_CYCLES - 1);

    ssm_pkg::ssm_bus_req_t bus;
    assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

    // request pins come from outside the clock domain
    logic [1:0] req_meta_reg;
    logic [1:0] req_sync_reg;
    logic [1:0] req_prev_reg;

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            req_meta_reg <= 2'h0;
            req_sync_reg <= 2'h0;
            req_prev_reg <= 2'h0;
        end
        else
        begin
            req_meta_reg <= {req_b_in, req_a_in};
            req_sync_reg <= req_meta_reg;
            req_prev_reg <= req_sync_reg;
        end
    end

    // flag decode with cross-coupling
    function automatic ssm_pkg::ssm_flags_t decode(input logic [1:0] own, input logic [1:0] other);
        ssm_pkg::ssm_flags_t f;
        f = '{mon: 1'b0, safe: 1'b0, hbb: 1'b0};
        case (ssm_pkg::ssm_state_t'(own))
            ssm_pkg::SSM_ST_STANDBY: f = '{mon: 1'b0, safe: 1'b0, hbb: 1'b0};
            ssm_pkg::SSM_ST_MONITOR: f = '{mon: 1'b1, safe: 1'b0, hbb: 1'b0};
            ssm_pkg::SSM_ST_SAFE:    f = '{mon: 1'b1, safe: 1'b1, hbb: 1'b0};
            ssm_pkg::SSM_ST_HBB:     f = '{mon: 1'b0, safe: 1'b1, hbb: 1'b1};
            default:                 f = '{mon: 1'b0, safe: 1'b0, hbb: 1'b0};
        endcase
        // baseblock on the other side overrides any active state
        if (ssm_pkg::ssm_state_t'(other) == ssm_pkg::SSM_ST_HBB &&
            ssm_pkg::ssm_state_t'(own) != ssm_pkg::SSM_ST_STANDBY)
        begin
            f = '{mon: 1'b0, safe: 1'b1, hbb: 1'b1};
        end
        return f;
    endfunction

    ssm_pkg::ssm_flags_t fa;
    ssm_pkg::ssm_flags_t fb;
    logic [7:0] func_next;
    logic [7:0] sys_next;

    always_comb
    begin
        fa = decode(state_a_in, state_b_in);
        fb = decode(state_b_in, state_a_in);
        func_next = 8'h00;
        func_next[ssm_pkg::BIT_A_MON]  = fa.mon;
        func_next[ssm_pkg::BIT_A_SAFE] = fa.safe;
        func_next[ssm_pkg::BIT_A_HBB]  = fa.hbb;
        func_next[ssm_pkg::BIT_B_MON]  = fb.mon;
        func_next[ssm_pkg::BIT_B_SAFE] = fb.safe;
        func_next[ssm_pkg::BIT_B_HBB]  = fb.hbb;
        sys_next = 8'h00;
        sys_next[ssm_pkg::BIT_SYS_MON]  = fa.mon | fb.mon;
        sys_next[ssm_pkg::BIT_SYS_SAFE] = fa.safe & fb.safe;
        sys_next[ssm_pkg::BIT_SYS_HBB]  = fa.hbb | fb.hbb;
    end

    logic [7:0] func_reg;
    logic [7:0] sys_reg;

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            func_reg <= 8'h00;
            sys_reg  <= 8'h00;
        end
        else
        begin
            func_reg <= func_next;
            sys_reg  <= sys_next;
        end
    end

    assign func_flags_out = func_reg;
    assign sys_flags_out  = sys_reg;

    // configuration registers
    logic [3:0]                  cfg_reg;
    logic [ssm_pkg::SPEED_W-1:0] limit_speed_reg;
    logic [ssm_pkg::SPEED_W-1:0] err_speed_reg;
    logic [ssm_pkg::IRQ_W-1:0]   irq_mask_reg;

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            cfg_reg         <= ssm_pkg::CFG_RESET;
            limit_speed_reg <= ssm_pkg::LIMIT_SPEED_RESET;
            err_speed_reg   <= ssm_pkg::ERR_SPEED_RESET;
            irq_mask_reg    <= '0;
        end
        else if (bus.wr)
        begin
            case (bus.addr)
                ssm_pkg::ADDR_CFG:         cfg_reg <= bus.wdata[3:0];
                ssm_pkg::ADDR_LIMIT_SPEED: limit_speed_reg <= bus.wdata;
                ssm_pkg::ADDR_ERR_SPEED:   err_speed_reg <= bus.wdata;
                ssm_pkg::ADDR_IRQ_MASK:    irq_mask_reg <= bus.wdata[ssm_pkg::IRQ_W-1:0];
                default:                   ;
            endcase
        end
    end

    // shared millisecond tick; a shared base trades up to 1 ms start jitter for one counter
    logic [15:0] tick_cnt_reg;
    logic        tick;

    assign tick = (tick_cnt_reg == TICK_MAX);

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            tick_cnt_reg <= 16'h0000;
        else if (tick)
            tick_cnt_reg <= 16'h0000;
        else
            tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end

    // per-function timers
    logic [1:0]        sel [2];
    logic [1:0]        sel_bb;
    logic [1:0]        req_rise;
    logic [1:0]        measuring_reg;
    logic [1:0]        arrived;
    logic [1:0]        arrive_edge;
    logic [1:0]        cap_zero;
    logic [1:0]        cap_run;
    logic [1:0]        was_safe_reg;
    logic [TIME_W-1:0] run_reg [2];
    logic [TIME_W-1:0] time_reg [2];

    assign sel[0] = cfg_reg[ssm_pkg::CFG_SEL_A_LSB +: 2];
    assign sel[1] = cfg_reg[ssm_pkg::CFG_SEL_B_LSB +: 2];

    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            sel_bb[i]   = (ssm_pkg::ssm_sel_t'(sel[i]) == ssm_pkg::SSM_SEL_BASEBLOCK);
            req_rise[i] = req_sync_reg[i] && !req_prev_reg[i];
            case (ssm_pkg::ssm_sel_t'(sel[i]))
                ssm_pkg::SSM_SEL_BB_DECEL,
                ssm_pkg::SSM_SEL_POS_DECEL:   arrived[i] = (speed_in <= err_speed_reg);
                ssm_pkg::SSM_SEL_LIMIT_DECEL: arrived[i] = (speed_in <= limit_speed_reg);
                default:                      arrived[i] = 1'b0;
            endcase
            arrive_edge[i] = arrived[i] && !was_safe_reg[i];
            // already at safe speed when the request comes: the time is zero
            cap_zero[i] = !sel_bb[i] && req_rise[i] && arrived[i];
            // only while watching, so a late mode change cannot store a stale count
            cap_run[i]  = !sel_bb[i] && !req_rise[i] && req_sync_reg[i] && measuring_reg[i] && arrive_edge[i];
        end
    end

    // arrival edge detector; cfg resets to plain baseblock, so no false edge after reset
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            was_safe_reg <= 2'h0;
        else
            was_safe_reg <= arrived;
    end

    // a mode change to plain baseblock drops any running measurement
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            measuring_reg <= 2'h0;
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (sel_bb[i])
                    measuring_reg[i] <= 1'b0;
                else if (req_rise[i])
                    measuring_reg[i] <= 1'b1;
                else if (!req_sync_reg[i])
                    measuring_reg[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            for (int i = 0; i < 2; i++)
                run_reg[i] <= '0;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (sel_bb[i] || req_rise[i])
                    run_reg[i] <= '0;
                // count while watching, stop at safe speed
                else if (measuring_reg[i] && req_sync_reg[i] && !arrived[i] && tick && run_reg[i] != '1)
                    run_reg[i] <= run_reg[i] + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            for (int i = 0; i < 2; i++)
                time_reg[i] <= '0;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (sel_bb[i] || cap_zero[i])
                    time_reg[i] <= '0;
                // store on each arrival at safe speed
                else if (cap_run[i])
                    time_reg[i] <= run_reg[i];
            end
        end
    end

    // interrupt: sticky arrival flags, write one to clear, set wins
    logic [ssm_pkg::IRQ_W-1:0] irq_stat_reg;
    logic [ssm_pkg::IRQ_W-1:0] irq_set;
    logic [ssm_pkg::IRQ_W-1:0] irq_clr;

    always_comb
    begin
        for (int i = 0; i < 2; i++)
            irq_set[i] = cap_zero[i] || cap_run[i];
        irq_clr = (bus.wr && bus.addr == ssm_pkg::ADDR_IRQ_STATUS) ?
                  bus.wdata[ssm_pkg::IRQ_W-1:0] : '0;
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            irq_stat_reg <= '0;
        else
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
    end

    assign irq_out = |(irq_stat_reg & irq_mask_reg);

    // read port, data valid in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            rdata_out <= '0;
        else if (bus.rd)
        begin
            case (bus.addr)
                ssm_pkg::ADDR_FUNC_FLAGS:  rdata_out <= {8'h00, func_reg};
                ssm_pkg::ADDR_SYS_FLAGS:   rdata_out <= {8'h00, sys_reg};
                ssm_pkg::ADDR_TIME_A:      rdata_out <= ssm_pkg::DATA_W'(time_reg[0]);
                ssm_pkg::ADDR_TIME_B:      rdata_out <= ssm_pkg::DATA_W'(time_reg[1]);
                ssm_pkg::ADDR_CFG:         rdata_out <= {12'h000, cfg_reg};
                ssm_pkg::ADDR_LIMIT_SPEED: rdata_out <= limit_speed_reg;
                ssm_pkg::ADDR_ERR_SPEED:   rdata_out <= err_speed_reg;
                ssm_pkg::ADDR_IRQ_STATUS:  rdata_out <= {14'h0000, irq_stat_reg};
                ssm_pkg::ADDR_IRQ_MASK:    rdata_out <= {14'h0000, irq_mask_reg};
                default:                   rdata_out <= '0;
            endcase
        end
        else
            rdata_out <= '0;
    end

endmodule

// ### hdl/ssm_pkg.sv
// package: register map, field layout, timing and mode types for the safety status monitor
package ssm_pkg;

    // register offsets on the plain register port
    localparam logic [3:0] ADDR_FUNC_FLAGS  = 4'h0;
    localparam logic [3:0] ADDR_SYS_FLAGS   = 4'h1;
    localparam logic [3:0] ADDR_TIME_A      = 4'h2;
    localparam logic [3:0] ADDR_TIME_B      = 4'h3;
    localparam logic [3:0] ADDR_CFG         = 4'h4;
    localparam logic [3:0] ADDR_LIMIT_SPEED = 4'h5;
    localparam logic [3:0] ADDR_ERR_SPEED   = 4'h6;
    localparam logic [3:0] ADDR_IRQ_STATUS  = 4'h7;
    localparam logic [3:0] ADDR_IRQ_MASK    = 4'h8;

    localparam int DATA_W  = 16;
    localparam int SPEED_W = 16;

    // function flag bit positions
    localparam int BIT_A_MON  = 0;
    localparam int BIT_A_SAFE = 1;
    localparam int BIT_A_HBB  = 2;
    localparam int BIT_B_MON  = 4;
    localparam int BIT_B_SAFE = 5;
    localparam int BIT_B_HBB  = 6;

    // system flag bit positions
    localparam int BIT_SYS_MON  = 0;
    localparam int BIT_SYS_SAFE = 1;
    localparam int BIT_SYS_HBB  = 2;

    // interrupt bits: safe speed reached, a then b
    localparam int BIT_IRQ_A = 0;
    localparam int BIT_IRQ_B = 1;
    localparam int IRQ_W     = 2;

    // config register: function select a at [1:0], b at [3:2]
    localparam int CFG_SEL_A_LSB = 0;
    localparam int CFG_SEL_B_LSB = 2;
    localparam logic [3:0] CFG_RESET = 4'h0;

    localparam logic [SPEED_W-1:0] LIMIT_SPEED_RESET = 16'h0064;
    localparam logic [SPEED_W-1:0] ERR_SPEED_RESET   = 16'h000a;

    // timing
    localparam int CLK_HZ     = 10_000_000;
    localparam int TICK_US    = 1000;
    localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;

    typedef enum logic [1:0] {
        SSM_SEL_BASEBLOCK,
        SSM_SEL_BB_DECEL,
        SSM_SEL_POS_DECEL,
        SSM_SEL_LIMIT_DECEL
    } ssm_sel_t;

    typedef enum logic [1:0] {
        SSM_ST_STANDBY,
        SSM_ST_MONITOR,
        SSM_ST_SAFE,
        SSM_ST_HBB
    } ssm_state_t;

    typedef struct packed {
        logic mon;
        logic safe;
        logic hbb;
    } ssm_flags_t;

    typedef struct packed {
        logic [3:0]        addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } ssm_bus_req_t;

endpackage

// ### verification/ssm_monitor_assertions.sv
// checker: port-level properties of the safety status monitor
`timescale 1ns/1ns
module ssm_monitor_chk (
    input wire logic        clk_sys_in,
    input wire logic        nrst_in,
    input wire logic [1:0]  state_a_in,
    input wire logic [1:0]  state_b_in,
    input wire logic        req_a_in,
    input wire logic        req_b_in,
    input wire logic [15:0] speed_in,
    input wire logic [3:0]  addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [15:0] rdata_out,
    input wire logic [7:0]  func_flags_out,
    input wire logic [7:0]  sys_flags_out,
    input wire logic        irq_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!nrst_in);

    // {hbb, safe, mon}; the other side in baseblock overrides an active function
    function automatic logic [2:0] fl(input logic [1:0] me, input logic [1:0] ot);
        if (me == 2'h0)
            return 3'h0;
        if (me == 2'h3 || ot == 2'h3)
            return 3'h6;
        return (me == 2'h2) ? 3'h3 : 3'h1;
    endfunction

    res_bits_a: assert property (func_flags_out[3] == 1'b0 && func_flags_out[7] == 1'b0)
        else $error("reserved function flag bit set");
    a_flags_a: assert property ($past(nrst_in)
        |-> func_flags_out[2:0] == fl($past(state_a_in), $past(state_b_in)))
        else $error("function a flags wrong");
    b_flags_a: assert property ($past(nrst_in)
        |-> func_flags_out[6:4] == fl($past(state_b_in), $past(state_a_in)))
        else $error("function b flags wrong");
    sys_mon_a: assert property (sys_flags_out[0] == (func_flags_out[0] | func_flags_out[4]))
        else $error("system monitoring bit wrong");
    sys_safe_a: assert property (sys_flags_out[1] == (func_flags_out[1] & func_flags_out[5]))
        else $error("system safe bit wrong");
    sys_hbb_a: assert property (sys_flags_out[2] == (func_flags_out[2] | func_flags_out[6]))
        else $error("system baseblock bit wrong");
    rd_func_a: assert property ($past(rd_in) && $past(addr_in) == ssm_pkg::ADDR_FUNC_FLAGS
        && $stable(func_flags_out) |-> rdata_out == {8'h00, func_flags_out}) else $error("function flag read wrong");
    irq_mask_a: assert property ($past(wr_in) && $past(addr_in) == ssm_pkg::ADDR_IRQ_MASK
        && ($past(wdata_in) & 16'h0003) == 16'h0000 |-> !irq_out) else $error("masked interrupt still high");
endmodule

bind ssm_monitor ssm_monitor_chk u_chk (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .state_a_in(state_a_in), .state_b_in(state_b_in),
    .req_a_in(req_a_in), .req_b_in(req_b_in), .speed_in(speed_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .func_flags_out(func_flags_out),
    .sys_flags_out(sys_flags_out), .irq_out(irq_out));

// ### verification/ssm_motor_model.sv
// partner model: motor speed source that ramps down while decelerating
`timescale 1ns/1ns
module ssm_motor_model #(
    parameter logic [15:0] START = 16'h01f4,
    parameter logic [15:0] STEP  = 16'h0005
) (
    input  wire logic        clk_sys_in,
    input  wire logic        nrst_in,
    input  wire logic        load_in,
    input  wire logic        decel_in,
    output logic      [15:0] speed_out
);
    // linear ramp keeps arrival moments predictable; real motors are not this kind
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            speed_out <= START;
        else if (load_in)
            speed_out <= START;
        else if (decel_in)
            speed_out <= (speed_out > STEP) ? speed_out - STEP : 16'h0000;
    end
endmodule

// ### verification/ssm_monitor_tb.sv
// testbench: register, flag table and timer scenarios for the safety status monitor
`timescale 1ns/1ns
module ssm_monitor_tb;
    localparam int TICK    = 10;
    localparam int CROSS_A = 98;
    localparam int CROSS_B = 80;
    logic        clk_sys_in, nrst_in, req_a, req_b, wr, rd, load, decel, irq;
    logic [1:0]  state_a, state_b;
    logic [3:0]  addr;
    logic [2:0]  ea, eb;
    logic [15:0] wdata, rdata, rdv, t_old, speed;
    logic [7:0]  func_flags, sys_flags;
    int          err_total, n_tests;

    ssm_monitor #(.TICK_CYCLES(TICK)) dut (
        .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .state_a_in(state_a), .state_b_in(state_b),
        .req_a_in(req_a), .req_b_in(req_b), .speed_in(speed), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
        .rd_in(rd), .rdata_out(rdata), .func_flags_out(func_flags), .sys_flags_out(sys_flags), .irq_out(irq));
    ssm_motor_model motor (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .load_in(load), .decel_in(decel),
        .speed_out(speed));

    function automatic logic [2:0] fl(input logic [1:0] me, input logic [1:0] ot);
        if (me == 2'h0)
            return 3'h0;
        if (me == 2'h3 || ot == 2'h3)
            return 3'h6;
        return (me == 2'h2) ? 3'h3 : 3'h1;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input logic [15:0] got, input int lo, input int hi);
        n_tests++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            err_total++;
            $display("MISMATCH t=%0t got %0d range %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys_in);
        wr <= 1'b0;
        #1;
    endtask
    task automatic bus_rd(input logic [3:0] a);
        @(posedge clk_sys_in);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys_in);
        rd <= 1'b0;
        #1;
        rdv = rdata;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        bus_rd(a);
        chk(rdv, e);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end
    initial
    begin
        repeat (5000) @(posedge clk_sys_in);
        err_total++;
        wrap_up();
    end
    initial
    begin
        {nrst_in, req_a, req_b, wr, rd, load, decel, state_a, state_b, addr, wdata} = '0;
        err_total = 0;
        n_tests = 0;
        repeat (6) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        rd_chk(ssm_pkg::ADDR_TIME_A, 16'h0000);
        rd_chk(ssm_pkg::ADDR_TIME_B, 16'h0000);
        rd_chk(ssm_pkg::ADDR_ERR_SPEED, 16'h000a);
        rd_chk(ssm_pkg::ADDR_LIMIT_SPEED, 16'h0064);
        rd_chk(4'hf, 16'h0000);
        bus_wr(ssm_pkg::ADDR_FUNC_FLAGS, 16'hffff);
        rd_chk(ssm_pkg::ADDR_FUNC_FLAGS, 16'h0000);
        // every pairing of the two function states
        for (int i = 0; i < 16; i++)
        begin
            @(posedge clk_sys_in);
            state_a <= i[1:0];
            state_b <= i[3:2];
            ea = fl(i[1:0], i[3:2]);
            eb = fl(i[3:2], i[1:0]);
            rd_chk(ssm_pkg::ADDR_FUNC_FLAGS, {8'h00, 1'b0, eb, 1'b0, ea});
            rd_chk(ssm_pkg::ADDR_SYS_FLAGS, {13'h0, ea[2] | eb[2], ea[1] & eb[1], ea[0] | eb[0]});
        end
        bus_wr(ssm_pkg::ADDR_CFG, 16'h000d);
        @(posedge clk_sys_in);
        req_a <= 1'b1;
        req_b <= 1'b1;
        decel <= 1'b1;
        repeat (120) @(posedge clk_sys_in);
        #1;
        chk({15'h0, irq}, 16'h0000);
        bus_rd(ssm_pkg::ADDR_TIME_A);
        chk_rng(rdv, (CROSS_A - 4) / TICK - 1, (CROSS_A + 1) / TICK + 1);
        t_old = rdv;
        bus_rd(ssm_pkg::ADDR_TIME_B);
        chk_rng(rdv, (CROSS_B - 4) / TICK - 1, (CROSS_B + 1) / TICK + 1);
        bus_wr(ssm_pkg::ADDR_IRQ_MASK, 16'h0003);
        chk({15'h0, irq}, 16'h0001);
        rd_chk(ssm_pkg::ADDR_IRQ_STATUS, 16'h0003);
        bus_wr(ssm_pkg::ADDR_IRQ_STATUS, 16'h0001);
        chk({15'h0, irq}, 16'h0001);
        bus_wr(ssm_pkg::ADDR_IRQ_STATUS, 16'h0002);
        chk({15'h0, irq}, 16'h0000);
        // second arrival while the request stays on; function a now in position mode
        bus_wr(ssm_pkg::ADDR_CFG, 16'h000e);
        @(posedge clk_sys_in);
        load <= 1'b1;
        @(posedge clk_sys_in);
        load <= 1'b0;
        repeat (110) @(posedge clk_sys_in);
        bus_rd(ssm_pkg::ADDR_TIME_A);
        chk_rng(rdv, t_old + CROSS_A / TICK - 1, t_old + CROSS_A / TICK + 1);
        t_old = rdv;
        chk({15'h0, irq}, 16'h0001);
        bus_wr(ssm_pkg::ADDR_IRQ_MASK, 16'h0000);
        chk({15'h0, irq}, 16'h0000);
        // request off: a later arrival must not touch the stored time
        @(posedge clk_sys_in);
        req_a <= 1'b0;
        req_b <= 1'b0;
        load <= 1'b1;
        @(posedge clk_sys_in);
        load <= 1'b0;
        repeat (110) @(posedge clk_sys_in);
        rd_chk(ssm_pkg::ADDR_TIME_A, t_old);
        // request again at standstill: already at safe speed, so the time is zero
        @(posedge clk_sys_in);
        req_a <= 1'b1;
        repeat (6) @(posedge clk_sys_in);
        rd_chk(ssm_pkg::ADDR_TIME_A, 16'h0000);
        bus_wr(ssm_pkg::ADDR_CFG, 16'h0000);
        rd_chk(ssm_pkg::ADDR_TIME_A, 16'h0000);
        rd_chk(ssm_pkg::ADDR_TIME_B, 16'h0000);
        wrap_up();
    end
endmodule
